// >>> csfm_pkg.sv
package csfm_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OSC_CONTROL_OFFSET   = 8'h00;  // oscillator_control
  localparam logic [7:0] CLK_CONFIG_OFFSET    = 8'h04;  // clock_config_high
  localparam logic [7:0] IRQ_FLAG_OFFSET      = 8'h08;  // peripheral_irq_flag_two
  localparam logic [7:0] IRQ_ENABLE_OFFSET    = 8'h0C;  // peripheral_irq_enable_two
  localparam logic [7:0] CLK_STATUS_OFFSET    = 8'h10;  // live switch status

  // oscillator_control field positions
  localparam int IDLE_ENABLE_BIT  = 7;
  localparam int IFS_LSB          = 4;
  localparam int OST_STATUS_BIT   = 3;
  localparam int INT_STABLE_BIT   = 2;
  localparam int SCS_LSB          = 0;
  // clock_config_high field positions
  localparam int TWO_SPEED_BIT    = 7;
  localparam int FAILSAFE_EN_BIT  = 6;
  localparam int PCFG_LSB         = 0;
  // flag and enable bit position
  localparam int OSC_FAIL_BIT     = 7;

  // values after reset
  localparam logic       IDLE_ENABLE_RST = 1'b0;
  localparam logic [2:0] IFS_RST         = 3'h3;
  localparam logic [1:0] SCS_RST         = 2'h0;
  localparam logic       TWO_SPEED_RST   = 1'b0;
  localparam logic       FAILSAFE_EN_RST = 1'b0;
  localparam logic [3:0] PCFG_RST        = 4'h2;

  // primary oscillator configuration codes
  localparam logic [3:0] PCFG_LOW_POWER_XTAL  = 4'h0;
  localparam logic [3:0] PCFG_STANDARD_XTAL   = 4'h1;
  localparam logic [3:0] PCFG_HIGH_SPEED_XTAL = 4'h2;
  localparam logic [3:0] PCFG_EXTERNAL_CLOCK  = 4'h4;
  localparam logic [3:0] PCFG_RC              = 4'h6;
  localparam logic [3:0] PCFG_INTERNAL_OSC    = 4'h8;

  // clock select codes
  localparam logic [1:0] SCS_PRIMARY   = 2'h0;
  localparam logic [1:0] SCS_SECONDARY = 2'h1;

  // counts
  localparam int unsigned OST_CYCLES   = 1024;  // start-up timer oscillations
  localparam int unsigned OLD_EDGES    = 2;     // old clock rises before the hold
  localparam int unsigned NEW_EDGES    = 2;     // new clock rises during the hold
  localparam int unsigned FAILSAFE_MONITOR_DIV     = 64;    // slow osc divide for sample clock
  localparam int unsigned SAMP_W       = $clog2(FAILSAFE_MONITOR_DIV);
  localparam int unsigned POST_W       = 7;     // postscaler counter width

  // synchroniser lanes
  localparam int SY_PRI = 0;
  localparam int SY_SEC = 1;
  localparam int SY_FAST = 2;
  localparam int SY_SLOW = 3;
  localparam int SY_SEC_RDY = 4;
  localparam int SY_INT_STB = 5;
  localparam int SY_W = 6;

  typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} csfm_src_type;
  typedef enum logic [2:0] {SW_IDLE, SW_WAIT_RDY, SW_OLD_EDGE, SW_HOLD, SW_NEW_EDGE,
                            SW_NEW_FALL} csfm_sw_type;

endpackage

// >>> csfm_clock_switch.sv
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/10ps

module csfm_clock_switch #(
  parameter int unsigned OST_COUNT = csfm_pkg::OST_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        prim_osc_in,
  input  wire logic        sec_osc_in,
  input  wire logic        fast_int_osc_in,
  input  wire logic        slow_int_osc_in,
  input  wire logic        sec_osc_ready_in,
  input  wire logic        internal_stable_in,
  input  wire logic        powerup_done_in,
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  output logic             sys_clk_out,
  output logic             cpu_clk_en_out,
  output logic      [1:0]  clk_src_out,
  output logic             osc_fail_irq_out
);

  // all state of the block in one record
  typedef struct packed {
    logic [csfm_pkg::SY_W-1:0]   sy1;          // first synchroniser stage
    logic [csfm_pkg::SY_W-1:0]   sy2;          // second stage, safe to use
    logic [csfm_pkg::SY_W-1:0]   sy3;          // previous sy2, for edges
    logic                        pready;       // apb ready
    logic                        pslverr;      // apb error
    logic [31:0]                 prdata;       // apb read data
    logic                        idle_en;      // idle_enable
    logic [2:0]                  ifs;          // internal_freq_select
    logic [1:0]                  scs;          // clock_source_select
    logic                        two_spd;      // two_speed_enable
    logic                        fcm_en;       // failsafe_monitor_enable
    logic [3:0]                  pcfg;         // primary_osc_config
    logic                        fail_flag;    // oscillator_fail_flag
    logic                        fail_ie;      // oscillator_fail_irq_enable
    logic                        ost_run;      // start-up timer counting
    logic                        ost_done;     // start-up timer expired
    logic [10:0]                 ost_cnt;      // oscillations counted
    csfm_pkg::csfm_src_type      cur_src;      // source feeding the clock tree
    csfm_pkg::csfm_src_type      new_src;      // source being switched in
    csfm_pkg::csfm_sw_type       sw;           // switch sequencer state
    logic [1:0]                  edge_cnt;     // edges seen in a switch step
    logic                        hold;         // system clock held low
    logic [csfm_pkg::POST_W-1:0] post_cnt;     // fast osc postscaler
    logic [csfm_pkg::SAMP_W-1:0] samp_cnt;     // slow osc divider
    logic                        fs_latch;     // fail detector latch
    logic                        fail_active;  // fail-safe condition
    logic                        fs_clr_pend;  // clear waits for timer
    logic                        sleeping;     // all clocks stopped
    logic                        idling;       // cpu stopped only
    logic                        sys_clk;      // registered clock tree level
    logic                        cpu_en;       // registered cpu enable
    logic                        irq;          // registered interrupt request
  } csfm_state_type;

  csfm_state_type st_reg;
  csfm_state_type st_next;

  // combinational helpers
  logic                   crystal;       // primary is a crystal mode
  logic                   prim_ext;      // primary is an external source
  logic [5:0]             rise;          // rising edges per lane
  logic [5:0]             fall;          // falling edges per lane
  logic                   int_lvl;       // internal clock after postscaler
  logic                   samp_rise;     // sample clock rising
  logic                   samp_fall;     // sample clock falling
  logic                   held_off;      // crystal not yet allowed to run
  logic                   fs_armed;      // monitor allowed to fire
  logic                   fail_det;      // failure seen this cycle
  logic                   wr_en;         // apb write completes
  logic                   rd_phase;      // first access cycle
  logic                   restart;       // start-up timer restart request
  csfm_pkg::csfm_src_type target;        // source the block should run on
  logic [31:0]            rdata;         // decoded read value
  logic                   addr_ok;       // address is mapped

  // level of a source as seen by the clock tree
  function automatic logic src_lvl(input csfm_pkg::csfm_src_type s,
                                   input logic [5:0] sy, input logic il);
    logic v;
    v = il;
    case (s)
      csfm_pkg::SRC_PRI: v = sy[csfm_pkg::SY_PRI];
      csfm_pkg::SRC_SEC: v = sy[csfm_pkg::SY_SEC];
      default:           v = il;
    endcase
    return v;
  endfunction

  // next-state logic for the whole block
  always_comb begin
    st_next  = st_reg;
    crystal  = (st_reg.pcfg == csfm_pkg::PCFG_LOW_POWER_XTAL) ||
               (st_reg.pcfg == csfm_pkg::PCFG_STANDARD_XTAL) ||
               (st_reg.pcfg == csfm_pkg::PCFG_HIGH_SPEED_XTAL);
    prim_ext = (st_reg.pcfg != csfm_pkg::PCFG_INTERNAL_OSC);
    // sources pass two flops before anything looks at them
    st_next.sy1 = {internal_stable_in, sec_osc_ready_in, slow_int_osc_in,
                   fast_int_osc_in, sec_osc_in, prim_osc_in};
    st_next.sy2 = st_reg.sy1;
    st_next.sy3 = st_reg.sy2;
    rise = st_reg.sy2 & ~st_reg.sy3;
    fall = ~st_reg.sy2 & st_reg.sy3;

    // postscaler from the fast osc; zero select picks the slow osc directly
    if (rise[csfm_pkg::SY_FAST]) begin
      st_next.post_cnt = st_reg.post_cnt + 7'h01;
    end
    if (st_reg.ifs == 3'h0) begin
      int_lvl = st_reg.sy2[csfm_pkg::SY_SLOW];
    end else if (st_reg.ifs == 3'h7) begin
      int_lvl = st_reg.sy2[csfm_pkg::SY_FAST];
    end else begin
      // taps change immediately: old and new share one source
      int_lvl = st_reg.post_cnt[3'(3'h6 - st_reg.ifs)];
    end

    // sample clock is the slow osc over 64, taken from the top divider bit
    samp_rise = rise[csfm_pkg::SY_SLOW] && (st_reg.samp_cnt == 6'h1F);
    samp_fall = rise[csfm_pkg::SY_SLOW] && (st_reg.samp_cnt == 6'h3F);
    if (rise[csfm_pkg::SY_SLOW]) begin
      st_next.samp_cnt = st_reg.samp_cnt + 6'h01;
    end

    // fail detector latch: a falling edge of the primary sets it, the sample clock rise clears it
    if (fall[csfm_pkg::SY_PRI]) begin
      st_next.fs_latch = 1'b1;
    end else if (samp_rise) begin
      st_next.fs_latch = 1'b0;
    end
    fs_armed = st_reg.fcm_en && st_reg.ost_done && !st_reg.fail_active &&
               !st_reg.sleeping && prim_ext && (st_reg.scs == csfm_pkg::SCS_PRIMARY) &&
               (st_reg.cur_src == csfm_pkg::SRC_PRI);
    // a whole half-cycle after the clear with no falling edge on the primary
    fail_det = fs_armed && samp_fall && !st_reg.fs_latch && !fall[csfm_pkg::SY_PRI];

    // where the clock tree should end up; two-speed runs internal meanwhile
    if (st_reg.fail_active) begin
      target = csfm_pkg::SRC_INT;
    end else if (st_reg.scs == csfm_pkg::SCS_PRIMARY) begin
      if (crystal && !st_reg.ost_done && st_reg.two_spd) begin
        target = csfm_pkg::SRC_INT;
      end else begin
        target = csfm_pkg::SRC_PRI;
      end
    end else if (st_reg.scs == csfm_pkg::SCS_SECONDARY) begin
      target = csfm_pkg::SRC_SEC;
    end else begin
      target = csfm_pkg::SRC_INT;
    end

    // apb slave: one wait state, data and error set in the first access cycle
    rd_phase = psel && penable && !st_reg.pready;
    wr_en    = psel && penable && st_reg.pready && pwrite;
    addr_ok  = 1'b1;
    rdata    = 32'h0000_0000;
    case (paddr)
      csfm_pkg::OSC_CONTROL_OFFSET: begin
        rdata[csfm_pkg::IDLE_ENABLE_BIT] = st_reg.idle_en;
        rdata[csfm_pkg::IFS_LSB +: 3]    = st_reg.ifs;
        rdata[csfm_pkg::OST_STATUS_BIT]  = (st_reg.cur_src == csfm_pkg::SRC_PRI) &&
                                           (!crystal || st_reg.ost_done) &&
                                           !st_reg.sleeping &&
                                           (st_reg.sw == csfm_pkg::SW_IDLE);
        rdata[csfm_pkg::INT_STABLE_BIT]  = st_reg.sy2[csfm_pkg::SY_INT_STB];
        rdata[csfm_pkg::SCS_LSB +: 2]    = st_reg.scs;
      end
      csfm_pkg::CLK_CONFIG_OFFSET: begin
        rdata[csfm_pkg::TWO_SPEED_BIT]   = st_reg.two_spd;
        rdata[csfm_pkg::FAILSAFE_EN_BIT] = st_reg.fcm_en;
        rdata[csfm_pkg::PCFG_LSB +: 4]   = st_reg.pcfg;
      end
      csfm_pkg::IRQ_FLAG_OFFSET: begin
        rdata[csfm_pkg::OSC_FAIL_BIT] = st_reg.fail_flag;
      end
      csfm_pkg::IRQ_ENABLE_OFFSET: begin
        rdata[csfm_pkg::OSC_FAIL_BIT] = st_reg.fail_ie;
      end
      csfm_pkg::CLK_STATUS_OFFSET: begin
        rdata[1:0] = st_reg.cur_src;
        rdata[2]   = st_reg.fail_active;
        rdata[3]   = (st_reg.sw != csfm_pkg::SW_IDLE);
        rdata[4]   = st_reg.ost_done;
        rdata[5]   = st_reg.sleeping;
        rdata[6]   = st_reg.idling;
      end
      default: begin
        addr_ok = 1'b0;  // unmapped: zero data with an error
      end
    endcase
    st_next.pready = rd_phase;
    if (rd_phase) begin
      st_next.prdata  = rdata;
      st_next.pslverr = !addr_ok;
    end else if (!psel) begin
      st_next.pslverr = 1'b0;
    end

    // register writes
    restart = 1'b0;
    if (wr_en && addr_ok) begin
      case (paddr)
        csfm_pkg::OSC_CONTROL_OFFSET: begin
          st_next.idle_en = pwdata[csfm_pkg::IDLE_ENABLE_BIT];
          st_next.ifs     = pwdata[csfm_pkg::IFS_LSB +: 3];
          st_next.scs     = pwdata[csfm_pkg::SCS_LSB +: 2];
          // toggling the upper select bit starts the fail-safe clear
          if (pwdata[csfm_pkg::SCS_LSB + 1] != st_reg.scs[1]) begin
            restart = 1'b1;
          end
        end
        csfm_pkg::CLK_CONFIG_OFFSET: begin
          st_next.two_spd = pwdata[csfm_pkg::TWO_SPEED_BIT];
          st_next.fcm_en  = pwdata[csfm_pkg::FAILSAFE_EN_BIT];
          st_next.pcfg    = pwdata[csfm_pkg::PCFG_LSB +: 4];
        end
        csfm_pkg::IRQ_FLAG_OFFSET: begin
          // writing zero clears, even while the condition still stands
          if (!pwdata[csfm_pkg::OSC_FAIL_BIT]) begin
            st_next.fail_flag = 1'b0;
          end
        end
        csfm_pkg::IRQ_ENABLE_OFFSET: begin
          st_next.fail_ie = pwdata[csfm_pkg::OSC_FAIL_BIT];
        end
        default: begin
          // status register is read-only
        end
      endcase
    end

    // start-up timer; clock and rc modes finish at once
    if (restart) begin
      st_next.ost_run     = 1'b1;
      st_next.ost_done    = 1'b0;
      st_next.ost_cnt     = 11'h000;
      st_next.fs_clr_pend = st_reg.fail_active;
    end else if (st_reg.ost_run && powerup_done_in && !st_reg.sleeping) begin
      if (!crystal) begin
        st_next.ost_run  = 1'b0;
        st_next.ost_done = 1'b1;
      end else if (rise[csfm_pkg::SY_PRI]) begin
        if (st_reg.ost_cnt == 11'(OST_COUNT - 1)) begin
          st_next.ost_run  = 1'b0;
          st_next.ost_done = 1'b1;
        end else begin
          st_next.ost_cnt = st_reg.ost_cnt + 11'h001;
        end
      end
    end
    // timer expiry ends the fail-safe condition, back to external
    if (st_reg.fs_clr_pend && st_reg.ost_done && !restart) begin
      st_next.fail_active = 1'b0;
      st_next.fs_clr_pend = 1'b0;
    end

    // glitch-free switch sequencer
    case (st_reg.sw)
      csfm_pkg::SW_IDLE: begin
        if ((target != st_reg.cur_src) && !st_reg.sleeping) begin
          st_next.new_src = target;
          st_next.sw      = csfm_pkg::SW_WAIT_RDY;
        end
      end
      csfm_pkg::SW_WAIT_RDY: begin
        if (target == st_reg.cur_src) begin
          st_next.sw = csfm_pkg::SW_IDLE;
        end else if (target != st_reg.new_src) begin
          st_next.new_src = target;
        end else if ((st_reg.new_src == csfm_pkg::SRC_PRI &&
                      (!crystal || st_reg.ost_done)) ||
                     (st_reg.new_src == csfm_pkg::SRC_SEC &&
                      st_reg.sy2[csfm_pkg::SY_SEC_RDY]) ||
                     (st_reg.new_src == csfm_pkg::SRC_INT &&
                      (st_reg.sy2[csfm_pkg::SY_INT_STB] || st_reg.ifs == 3'h0))) begin
          st_next.sw       = csfm_pkg::SW_OLD_EDGE;
          st_next.edge_cnt = 2'h0;
        end
      end
      csfm_pkg::SW_OLD_EDGE: begin
        if (src_lvl(st_reg.cur_src, rise, 1'b0) ||
            (st_reg.cur_src == csfm_pkg::SRC_INT && int_lvl && !st_reg.sys_clk)) begin
          if (st_reg.edge_cnt == 2'(csfm_pkg::OLD_EDGES - 1)) begin
            st_next.sw = csfm_pkg::SW_HOLD;
          end else begin
            st_next.edge_cnt = st_reg.edge_cnt + 2'h1;
          end
        end
      end
      csfm_pkg::SW_HOLD: begin
        if (!src_lvl(st_reg.cur_src, st_reg.sy2, int_lvl) && st_reg.sys_clk) begin
          st_next.hold     = 1'b1;
          st_next.edge_cnt = 2'h0;
          st_next.sw       = csfm_pkg::SW_NEW_EDGE;
        end
      end
      csfm_pkg::SW_NEW_EDGE: begin
        if (src_lvl(st_reg.new_src, rise, 1'b0) ||
            (st_reg.new_src == csfm_pkg::SRC_INT && rise[csfm_pkg::SY_FAST])) begin
          if (st_reg.edge_cnt == 2'(csfm_pkg::NEW_EDGES - 1)) begin
            st_next.sw = csfm_pkg::SW_NEW_FALL;
          end else begin
            st_next.edge_cnt = st_reg.edge_cnt + 2'h1;
          end
        end
      end
      csfm_pkg::SW_NEW_FALL: begin
        if (!src_lvl(st_reg.new_src, st_reg.sy2, int_lvl)) begin
          st_next.hold    = 1'b0;
          st_next.cur_src = st_reg.new_src;
          st_next.sw      = csfm_pkg::SW_IDLE;
        end
      end
      default: begin
        st_next.sw   = csfm_pkg::SW_IDLE;
        st_next.hold = 1'b0;
      end
    endcase

    // a dead primary cannot give edges: jump straight to internal
    if (fail_det) begin
      st_next.cur_src     = csfm_pkg::SRC_INT;
      st_next.sw          = csfm_pkg::SW_IDLE;
      st_next.hold        = 1'b0;
      st_next.fail_active = 1'b1;
      st_next.fail_flag   = 1'b1;
    end

    // sleep and idle entry, wake-up
    if (sleep_req && !st_reg.sleeping && !st_reg.idling) begin
      if (st_reg.idle_en) begin
        st_next.idling = 1'b1;
      end else begin
        st_next.sleeping = 1'b1;
        st_next.ost_run  = 1'b0;
        st_next.ost_done = 1'b0;
        st_next.sw       = csfm_pkg::SW_IDLE;
        st_next.hold     = 1'b0;
      end
    end else if (wake_req && (st_reg.sleeping || st_reg.idling)) begin
      st_next.idling = 1'b0;
      if (st_reg.sleeping) begin
        // old clocks were stopped, so the new source is taken directly
        st_next.sleeping = 1'b0;
        st_next.ost_run  = 1'b1;
        st_next.ost_cnt  = 11'h000;
        st_next.cur_src  = target;
      end
    end

    // registered outputs; crystal without two-speed waits for the timer
    held_off = (st_reg.cur_src == csfm_pkg::SRC_PRI) && crystal && !st_reg.ost_done;
    st_next.sys_clk = !st_reg.sleeping && !st_reg.hold && !held_off &&
                      src_lvl(st_reg.cur_src, st_reg.sy2, int_lvl);
    st_next.cpu_en  = !st_reg.sleeping && !st_reg.idling && !st_reg.hold && !held_off;
    st_next.irq     = st_reg.fail_flag && st_reg.fail_ie;
  end

  // single state register; reset gives constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg             <= '0;
      st_reg.idle_en     <= csfm_pkg::IDLE_ENABLE_RST;
      st_reg.ifs         <= csfm_pkg::IFS_RST;
      st_reg.scs         <= csfm_pkg::SCS_RST;
      st_reg.two_spd     <= csfm_pkg::TWO_SPEED_RST;
      st_reg.fcm_en      <= csfm_pkg::FAILSAFE_EN_RST;
      st_reg.pcfg        <= csfm_pkg::PCFG_RST;
      st_reg.ost_run     <= 1'b1;
      st_reg.cur_src     <= csfm_pkg::SRC_PRI;
      st_reg.new_src     <= csfm_pkg::SRC_PRI;
      st_reg.sw          <= csfm_pkg::SW_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ports straight from the state register
  assign prdata           = st_reg.prdata;
  assign pready           = st_reg.pready;
  assign pslverr          = st_reg.pslverr;
  assign sys_clk_out      = st_reg.sys_clk;
  assign cpu_clk_en_out   = st_reg.cpu_en;
  assign clk_src_out      = st_reg.cur_src;
  assign osc_fail_irq_out = st_reg.irq;

endmodule

// >>> csfm_osc_model.sv
`timescale 1ns/10ps
// oscillator sources; periods differ, but each is a whole multiple of the pclk period
module csfm_osc_model (
  input  wire logic prim_run,
  output logic      prim_osc,
  output logic      sec_osc,
  output logic      fast_osc,
  output logic      slow_osc
);
  initial prim_osc = 1'h0;
  initial sec_osc  = 1'h0;
  initial fast_osc = 1'h0;
  initial slow_osc = 1'h0;
  // a dead crystal parks high, so the monitor sees no falling edge
  always #28 prim_osc = prim_run ? ~prim_osc : 1'h1;
  always #44 sec_osc = ~sec_osc;
  always #20 fast_osc = ~fast_osc;
  always #36 slow_osc = ~slow_osc;
endmodule

// >>> csfm_clock_switch_asserts.sv
`timescale 1ns/10ps
module csfm_clock_switch_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sleep_req,
  input wire logic        cpu_clk_en_out,
  input wire logic [1:0]  clk_src_out,
  input wire logic        osc_fail_irq_out
);
  logic [1:0] scs_reg;  // last select written by software
  logic       ien_reg;  // last fail enable written
  // shadows follow completed writes only, never hardware switches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scs_reg <= 2'h0;
      ien_reg <= 1'h0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == csfm_pkg::OSC_CONTROL_OFFSET) scs_reg <= pwdata[1:0];
      if (paddr == csfm_pkg::IRQ_ENABLE_OFFSET) ien_reg <= pwdata[7];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence done_s;
    psel && penable && pready;
  endsequence
  sequence rd_ctl_s;
    done_s ##0 !pwrite && paddr == csfm_pkg::OSC_CONTROL_OFFSET;
  endsequence
  sequence wr_sec_s;
    done_s ##0 pwrite && paddr == 8'h00 && pwdata[1:0] == 2'h1;
  endsequence
  rdy_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access left unanswered");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_map_a: assert property (done_s ##0 (paddr[1:0] != 2'h0 || paddr > 8'h10) |-> pslverr)
    else $error("unmapped access without error");
  upper_zero_a: assert property (done_s ##0 !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  sel_keep_a: assert property (rd_ctl_s |-> prdata[1:0] == scs_reg)
    else $error("clock select field changed by hardware");
  irq_gate_a: assert property (osc_fail_irq_out |-> ien_reg || $past(ien_reg))
    else $error("fail interrupt while disabled");
  sleep_stop_a: assert property (sleep_req |-> ##[1:8] !cpu_clk_en_out)
    else $error("cpu clock still on after sleep");
  sec_sel_a: assert property (wr_sec_s |-> ##[1:600] clk_src_out == 2'h1)
    else $error("secondary never selected");
  rst_src_a: assert property ($rose(presetn) |-> clk_src_out == 2'h0)
    else $error("source not primary after reset");
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] CTL = csfm_pkg::OSC_CONTROL_OFFSET;
  localparam logic [7:0] CFG = csfm_pkg::CLK_CONFIG_OFFSET;
  localparam logic [7:0] FLG = csfm_pkg::IRQ_FLAG_OFFSET;
  localparam logic [7:0] IEN = csfm_pkg::IRQ_ENABLE_OFFSET;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        prim_run = 1'h1;   // primary crystal alive
  logic        sec_rdy = 1'h0;    // secondary held not ready at first
  logic        pwr_done = 1'h0;   // power-up timer still running at first
  logic        sleep_req = 1'h0;
  logic        wake_req = 1'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr, sys_clk_out, cpu_clk_en_out, osc_fail_irq_out;
  logic [1:0]  clk_src_out;
  logic        prim_osc_in, sec_osc_in, fast_int_osc_in, slow_int_osc_in;
  int          miscompares = 0;
  int          num_checks = 0;
  always #4 pclk = ~pclk;
  csfm_osc_model osc (.prim_run, .prim_osc(prim_osc_in), .sec_osc(sec_osc_in),
    .fast_osc(fast_int_osc_in), .slow_osc(slow_int_osc_in));
  // short start-up count keeps the run brief
  csfm_clock_switch #(.OST_COUNT(8)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .prim_osc_in, .sec_osc_in,
    .fast_int_osc_in, .slow_int_osc_in, .sec_osc_ready_in(sec_rdy),
    .internal_stable_in(1'h1), .powerup_done_in(pwr_done), .sleep_req, .wake_req,
    .sys_clk_out, .cpu_clk_en_out, .clk_src_out, .osc_fail_irq_out);
  task automatic print_verdict;
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; pready is sampled at the rising edge, request still standing
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 64);
    if (n >= 64) begin
      miscompares++;
      print_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdat & m, e);
  endtask
  // bounded wait for the current source
  task automatic wsrc(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (clk_src_out !== s && n < 4000);
    chk({30'h0, clk_src_out}, {30'h0, s});
    if (n >= 4000) print_verdict();
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rd(CTL, 32'hFFFFFFF3, 32'h30);
    rd(CFG, 32'hFFFFFFFF, 32'h02);
    rd(FLG, 32'hFFFFFFFF, 32'h0);
    repeat (100) @(negedge pclk);
    chk({31'h0, sys_clk_out}, 32'h0);
    rd(CTL, 32'h8, 32'h0);
    pwr_done <= 1'h1;
    for (int i = 0; i < 60 && rdat[3] !== 1'h1; i++) apb(1'h0, CTL, 32'h0);
    chk(rdat & 32'h8, 32'h8);
    wsrc(2'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'h1, CTL, 32'h31);
    repeat (100) @(negedge pclk);
    chk({30'h0, clk_src_out}, 32'h0);
    @(posedge pclk);
    sec_rdy <= 1'h1;
    wsrc(2'h1);
    apb(1'h1, CTL, 32'h32);
    wsrc(2'h2);
    apb(1'h1, CTL, 32'h30);
    wsrc(2'h0);
    apb(1'h1, CFG, 32'h42);
    apb(1'h1, IEN, 32'h80);
    prim_run <= 1'h0;
    wsrc(2'h2);
    rd(FLG, 32'h80, 32'h80);
    @(negedge pclk);
    chk({31'h0, osc_fail_irq_out}, 32'h1);
    rd(CTL, 32'h3, 32'h0);
    apb(1'h1, FLG, 32'h0);
    rd(FLG, 32'h80, 32'h0);
    wsrc(2'h2);
    prim_run <= 1'h1;
    apb(1'h1, CTL, 32'h32);
    apb(1'h1, CTL, 32'h30);
    wsrc(2'h0);
    for (int i = 0; i < 40 && sys_clk_out !== 1'h1; i++) @(negedge pclk);
    chk({31'h0, sys_clk_out}, 32'h1);
    apb(1'h1, CFG, 32'hC2);
    sleep_req <= 1'h1;
    @(posedge pclk);
    sleep_req <= 1'h0;
    for (int i = 0; i < 20 && cpu_clk_en_out !== 1'h0; i++) @(negedge pclk);
    chk({31'h0, cpu_clk_en_out}, 32'h0);
    chk({31'h0, sys_clk_out}, 32'h0);
    @(posedge pclk);
    wake_req <= 1'h1;
    @(posedge pclk);
    wake_req <= 1'h0;
    for (int i = 0; i < 4000 && cpu_clk_en_out !== 1'h1; i++) @(negedge pclk);
    chk({31'h0, cpu_clk_en_out}, 32'h1);
    wsrc(2'h2);
    rd(CTL, 32'h8, 32'h0);
    wsrc(2'h0);
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end
endmodule
bind csfm_clock_switch csfm_clock_switch_asserts u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_req, .cpu_clk_en_out,
  .clk_src_out, .osc_fail_irq_out);
